/* dv/rps_host_model.sv */
// Purpose: Host processor model on the AXI4-Lite register bus
// Assumes: One write or one read at a time
// Notes:   Waits are bounded; ok stays low if the slave never answers
`timescale 1ns/1ps
module rps_host_model
  import rps_pkg::*;
(
  // Clock
  input wire logic          aclk,
  // Bus
  output rps_axil_req_s     req,
  input wire rps_axil_rsp_s rsp
);
  // ********************
  // Bus cycles
  // ********************
  initial req = '0;
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    output logic [1:0] r, output bit ok);
    ok = 1'b0;
    r  = 2'h3;
    @(posedge aclk);
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        r  = rsp.bresp;
        ok = 1'b1;
        req.bready <= 1'b0;
      end
    end
  endtask : wr
  // Read data taken at the edge where rvalid is seen
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                    output logic [1:0] r, output bit ok);
    ok = 1'b0;
    r  = 2'h3;
    @(posedge aclk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        d  = rsp.rdata;
        r  = rsp.rresp;
        ok = 1'b1;
        req.rready <= 1'b0;
      end
    end
  endtask : rd
endmodule : rps_host_model

/* dv/rps_sequencer_properties.sv */
// Purpose: Port-level checks on the shutdown sequencer
// Assumes: One aclk domain, synchronous active-low reset
// Notes:   Bound to every rps_sequencer instance
`timescale 1ns/1ps
module rps_sequencer_properties
  import rps_pkg::*;
(
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Inputs watched
  input wire rps_axil_req_s       axil_req,
  input wire rps_axil_rsp_s       axil_rsp,
  input wire rps_orders_t         fused_startup_order,
  input wire rps_orders_t         test_startup_order,
  input wire logic                test_mode_config_source,
  input wire logic                shutdown_req,
  input wire logic                power_up_done,
  // Outputs watched
  input wire logic [NUM_REGS-1:0] reg_enable,
  input wire rps_orders_t         startup_order,
  input wire logic                seq_busy,
  input wire logic                seq_done
);
  // ********************
  // Checks
  // ********************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [NUM_REGS-1:0] en_q;
  logic [8:0]          gap_q;
  wire                 fall = |(en_q & ~reg_enable);
  // Cycles since last switch-off; saturates so long idle never wraps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q  <= ENABLE_RST;
      gap_q <= 9'h1FF;
    end else begin
      en_q  <= reg_enable;
      gap_q <= fall ? 9'h000 : gap_q + {8'h00, ~&gap_q};
    end
  end
  a_startup_fixed: assert property (
    $past(aresetn) && $past(aresetn, 2) |-> $stable(startup_order))
    else $error("startup order changed after load");
  a_startup_source: assert property (
    $past(aresetn) && $past(aresetn, 2) |-> startup_order ==
    (test_mode_config_source ? test_startup_order : fused_startup_order))
    else $error("startup order not from selected source");
  a_enable_only_fall: assert property (
    !power_up_done |=> (reg_enable & ~$past(reg_enable)) == '0)
    else $error("regulator re-enabled without power-up");
  a_step_gap_min: assert property (
    fall && seq_busy |-> gap_q >= STEP_CYCLES - 1)
    else $error("shutdown steps too close");
  a_done_all_off: assert property (
    seq_done |-> reg_enable == '0)
    else $error("done with a regulator still on");
  a_trigger_start: assert property (
    $past(aresetn) && shutdown_req && !seq_busy && !seq_done
    |=> seq_busy || seq_done) else $error("shutdown trigger missed");
  a_write_resp: assert property (
    axil_req.awvalid && axil_rsp.awready && axil_req.wvalid &&
    axil_rsp.wready |-> ##2 axil_rsp.bvalid) else $error("no write response");
  a_read_resp: assert property (
    axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
    else $error("no read response");
  a_read_clear: assert property (
    axil_rsp.rvalid && axil_req.rready |=> !axil_rsp.rvalid)
    else $error("read response not released");
  c_bypass: cover property ($rose(seq_done) && !$past(seq_busy));
  c_step: cover property (fall && seq_busy);
  c_write: cover property (axil_rsp.bvalid && axil_req.bready);
endmodule : rps_sequencer_properties
bind rps_sequencer rps_sequencer_properties rps_sequencer_properties_inst (
  .aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
  .fused_startup_order(fused_startup_order),
  .test_startup_order(test_startup_order),
  .test_mode_config_source(test_mode_config_source),
  .shutdown_req(shutdown_req), .power_up_done(power_up_done),
  .reg_enable(reg_enable), .startup_order(startup_order),
  .seq_busy(seq_busy), .seq_done(seq_done));

/* dv/tb.sv */
// Purpose: Self-checking bench for the shutdown sequencer
// Assumes: 200 MHz aclk, host model on the register bus
// Notes:   Read table first, then hand-written sequencing cases
`timescale 1ns/1ps
module tb
  import rps_pkg::*;
;
  // ********************
  // Setup
  // ********************
  typedef struct packed {
    logic [7:0]        idx;
    logic [DATA_W-1:0] data;
    logic [1:0]        resp;
  } rps_row_s;
  localparam rps_orders_t FUSED = {3'h4, 3'h2, 3'h0, 3'h1, 3'h3, 3'h3, 3'h5};
  localparam rps_orders_t TEST  = {3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
  localparam rps_orders_t NEWO  = {3'h1, 3'h3, 3'h5, 3'h4, 3'h2, 3'h7, 3'h6};
  logic                aclk, aresetn, tmode, system_on;
  logic                shutdown_req, power_up_done, seq_busy, seq_done;
  logic [NUM_REGS-1:0] reg_enable;
  rps_orders_t         startup_order;
  rps_axil_req_s       axil_req;
  rps_axil_rsp_s       axil_rsp;
  rps_row_s            rows[11];
  int                  mismatches, samples_checked;
  rps_sequencer rps_sequencer_inst (
    .aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
    .fused_startup_order(FUSED), .test_startup_order(TEST),
    .test_mode_config_source(tmode), .system_on(system_on),
    .shutdown_req(shutdown_req), .power_up_done(power_up_done),
    .reg_enable(reg_enable), .startup_order(startup_order),
    .seq_busy(seq_busy), .seq_done(seq_done));
  rps_host_model rps_host_model_inst (
    .aclk(aclk), .req(axil_req), .rsp(axil_rsp));
  // Free-running 5 ns clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // ********************
  // Helpers
  // ********************
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input bit c, input string m);
    samples_checked++;
    if (!c) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, input logic [DATA_W-1:0] d,
                    input logic [1:0] er);
    logic [1:0] r;
    bit         ok;
    rps_host_model_inst.wr({i, 2'h0}, d, r, ok);
    if (!ok) begin
      mismatches++;
      print_verdict();
    end
    chk(r === er, "write response");
  endtask : wr
  task automatic rdc(input logic [7:0] i, input logic [DATA_W-1:0] ed,
                     input logic [1:0] er);
    logic [DATA_W-1:0] d;
    logic [1:0]        r;
    bit                ok;
    rps_host_model_inst.rd({i, 2'h0}, d, r, ok);
    if (!ok) begin
      mismatches++;
      print_verdict();
    end
    chk(d === ed && r === er, "read data or response");
  endtask : rdc
  task automatic do_reset(input logic tm);
    @(posedge aclk);
    aresetn <= 1'b0;
    tmode   <= tm;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask : do_reset
  // Trigger, log each switch-off cycle, then power back up
  task automatic run_seq(input rps_orders_t o, input bit sw);
    int f[NUM_REGS];
    int c;
    f = '{default: 0};
    if (sw) begin
      wr(IDX_CTRL, 32'h1, RESP_OKAY);
    end else begin
      @(posedge aclk);
      shutdown_req <= 1'b1;
    end
    for (c = 1; c < 4000 && seq_done !== 1'b1; c++) begin
      @(negedge aclk);
      for (int i = 0; i < NUM_REGS; i++)
        if (f[i] == 0 && reg_enable[i] === 1'b0) f[i] = c;
    end
    if (seq_done !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
    for (int i = 0; i < NUM_REGS; i++)
      for (int j = 0; j < NUM_REGS; j++)
        if (o[i] > o[j]) chk(f[j] - f[i] >= STEP_CYCLES, "order");
        else if (o[i] == o[j]) chk(f[i] == f[j], "level split");
    if (o == '0) chk(f[0] == 2, "bypass not at once");
    @(posedge aclk);
    shutdown_req <= 1'b0;
    @(posedge aclk);
    power_up_done <= 1'b1;
    @(posedge aclk);
    power_up_done <= 1'b0;
    @(negedge aclk);
    chk(reg_enable === ENABLE_RST, "enables not restored");
  endtask : run_seq
  // ********************
  // Main sequence
  // ********************
  initial begin
    aresetn       = 1'b0;
    tmode         = 1'b0;
    system_on     = 1'b1;
    shutdown_req  = 1'b0;
    power_up_done = 1'b0;
    for (int i = 0; i < NUM_REGS; i++)
      rows[i] = '{ORDER_IDX[i], {29'h0, FUSED[i]}, RESP_OKAY};
    rows[7] = '{IDX_START, {11'h000, FUSED}, RESP_OKAY};
    rows[8] = '{8'hFF, 32'h0, RESP_SLVERR};
    rows[9] = '{IDX_STATUS, 32'(ENABLE_RST) | (32'h1 << STAT_LOADED_BIT),
                RESP_OKAY};
    rows[10] = '{IDX_CTRL, 32'h0, RESP_OKAY};
    do_reset(1'b0);
    chk(reg_enable === ENABLE_RST && seq_busy === 1'b0, "reset");
    foreach (rows[k]) rdc(rows[k].idx, rows[k].data, rows[k].resp);
    run_seq(FUSED, 1'b0);
    // Writes outside system-on are dropped
    @(posedge aclk);
    system_on <= 1'b0;
    wr(IDX_BUCK1, 32'h0, RESP_OKAY);
    rdc(IDX_BUCK1, {29'h0, FUSED[0]}, RESP_OKAY);
    @(posedge aclk);
    system_on <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++)
      wr(ORDER_IDX[i], {29'h0, NEWO[i]}, RESP_OKAY);
    wr(IDX_START, 32'h0, RESP_SLVERR);
    chk(startup_order === FUSED, "startup order moved");
    run_seq(NEWO, 1'b0);
    for (int i = 0; i < NUM_REGS; i++)
      wr(ORDER_IDX[i], 32'h0, RESP_OKAY);
    run_seq('0, 1'b0);
    // Test-mode source selected across a second reset
    do_reset(1'b1);
    chk(startup_order === TEST, "test source not used");
    rdc(IDX_MEMREF, {29'h0, TEST[6]}, RESP_OKAY);
    // Software request through the control register
    run_seq(TEST, 1'b1);
    print_verdict();
  end
endmodule : tb

/* rtl/rps_axil_slave.sv */
// Purpose: AXI4-Lite slave front end for the sequencer registers
// Assumes: One write and one read at most in flight
// Notes:   Address and data are taken in either order; response follows

`timescale 1ns/1ps

module rps_axil_slave
  import rps_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Bus
  input  wire rps_axil_req_s     req,
  output rps_axil_rsp_s          rsp,
  // Register write side
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [DATA_W-1:0]      wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_ok,
  // Register read side
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              rd_ok
);

  typedef struct packed {
    logic              aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_full;
    logic [DATA_W-1:0] w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } rps_axs_s;

  rps_axs_s st_q;
  rps_axs_s st_d;
  logic     aw_rdy;
  logic     w_rdy;
  logic     ar_rdy;

  // Holding slots close while a response is still pending
  assign aw_rdy  = !st_q.aw_full && !st_q.bvalid;
  assign w_rdy   = !st_q.w_full && !st_q.bvalid;
  assign ar_rdy  = !st_q.rvalid;
  assign wr_en   = st_q.aw_full && st_q.w_full && !st_q.bvalid;
  assign wr_addr = st_q.aw_addr;
  assign wr_data = st_q.w_data;
  assign wr_strb = st_q.w_strb;
  assign rd_addr = req.araddr;

  // Capture channels, perform the write, form the responses
  always_comb begin
    st_d = st_q;
    if (req.awvalid && aw_rdy) begin
      st_d.aw_full = 1'b1;
      st_d.aw_addr = req.awaddr;
    end
    if (req.wvalid && w_rdy) begin
      st_d.w_full = 1'b1;
      st_d.w_data = req.wdata;
      st_d.w_strb = req.wstrb;
    end
    if (wr_en) begin
      st_d.aw_full = 1'b0;
      st_d.w_full  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st_q.bvalid && req.bready) begin
      st_d.bvalid = 1'b0;
    end
    if (req.arvalid && ar_rdy) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = rd_data;
      st_d.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st_q.rvalid && req.rready) begin
      st_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Response channel outputs
  always_comb begin
    rsp.awready = aw_rdy;
    rsp.wready  = w_rdy;
    rsp.bvalid  = st_q.bvalid;
    rsp.bresp   = st_q.bresp;
    rsp.arready = ar_rdy;
    rsp.rvalid  = st_q.rvalid;
    rsp.rdata   = st_q.rdata;
    rsp.rresp   = st_q.rresp;
  end

endmodule : rps_axil_slave

/* rtl/rps_pkg.sv */
// Purpose: Shared constants and carriers for the shutdown sequencer
// Assumes: 32-bit AXI4-Lite register bus, 200 MHz aclk
// Notes:   Register byte address is four times the register index

package rps_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_REGS  = 7;
  localparam int ORDER_W   = 3;
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 32;

  // ****************************************************************
  // Register indices and byte addresses
  // ****************************************************************
  localparam logic [7:0] IDX_BUCK1  = 8'h5F;
  localparam logic [7:0] IDX_BUCK2  = 8'h60;
  localparam logic [7:0] IDX_BUCK3  = 8'h61;
  localparam logic [7:0] IDX_LIN1   = 8'h62;
  localparam logic [7:0] IDX_LIN2   = 8'h63;
  localparam logic [7:0] IDX_LIN3   = 8'h64;
  localparam logic [7:0] IDX_MEMREF = 8'h65;
  localparam logic [7:0] IDX_CTRL   = 8'h6C;
  localparam logic [7:0] IDX_STATUS = 8'h6D;
  localparam logic [7:0] IDX_START  = 8'h6E;

  // Order registers indexed by regulator number
  localparam logic [NUM_REGS-1:0][7:0] ORDER_IDX = {
    IDX_MEMREF, IDX_LIN3, IDX_LIN2, IDX_LIN1,
    IDX_BUCK3, IDX_BUCK2, IDX_BUCK1};

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_SW_SHUTDOWN_BIT = 0;
  localparam int STAT_BUSY_BIT        = 8;
  localparam int STAT_DONE_BIT        = 9;
  localparam int STAT_LOADED_BIT      = 10;
  localparam logic [ORDER_W-1:0]  ORDER_RST  = 3'h0;
  localparam logic [NUM_REGS-1:0] ENABLE_RST = 7'h7F;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STEP_TIME_NS  = 1000;
  localparam int STEP_CYCLES   =
    (STEP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STEP_CNT_W    = 9;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_SCAN = 4'b0010,
    SEQ_WAIT = 4'b0100,
    SEQ_DONE = 4'b1000
  } rps_seq_e;

  typedef logic [NUM_REGS-1:0][ORDER_W-1:0] rps_orders_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } rps_axil_req_s;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } rps_axil_rsp_s;

endpackage : rps_pkg

/* rtl/rps_sequencer.sv */
// Purpose: Regulator shutdown sequencer with host-writable order fields
// Assumes: Fused and test-mode orders are static, on the aclk domain
// Notes:   Step interval is a fixed time, handled by rps_step_timer
//
// Functional notes
// - Seven separate 3-bit shutdown order fields, one per regulator.
// - After reset each shutdown field loads its regulator's startup order (fused, or test source when selected).
// - On shutdown, regulators turn off from highest order value downward.
// - Shutdown is the reverse of startup, using the same order values.
// - Host may rewrite fields while system is on; next shutdown uses them.
// - Startup order comes only from fuses or test source, never host writes.
// - All fields zero skips stepping; every regulator turns off at once.
//
// Local design decision: the AXI4-Lite interface to the registers.

`timescale 1ns/1ps

module rps_sequencer
  import rps_pkg::*;
(
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // Register bus
  input  wire rps_axil_req_s       axil_req,
  output rps_axil_rsp_s            axil_rsp,
  // Startup order sources
  input  wire rps_orders_t         fused_startup_order,
  input  wire rps_orders_t         test_startup_order,
  input  wire logic                test_mode_config_source,
  // System state
  input  wire logic                system_on,
  input  wire logic                shutdown_req,
  input  wire logic                power_up_done,
  // Regulator controls and status
  output logic [NUM_REGS-1:0]      reg_enable,
  output rps_orders_t              startup_order,
  output logic                     seq_busy,
  output logic                     seq_done
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    rps_seq_e              seq;
    logic                  load_pend;
    logic                  loaded;
    rps_orders_t           order;
    rps_orders_t           startup;
    rps_orders_t           snap;
    logic [ORDER_W-1:0]    level;
    logic [NUM_REGS-1:0]   enable;
    logic                  sw_trig;
  } rps_seq_s;

  rps_seq_s            st_q;
  rps_seq_s            st_d;

  logic                wr_en;
  logic [ADDR_W-1:0]   wr_addr;
  logic [DATA_W-1:0]   wr_data;
  logic [3:0]          wr_strb;
  logic                wr_ok;
  logic [ADDR_W-1:0]   rd_addr;
  logic [DATA_W-1:0]   rd_data;
  logic                rd_ok;
  logic                tmr_start;
  logic                tmr_busy;
  logic [NUM_REGS-1:0] level_hit;
  logic                all_zero;
  logic                trigger;
  logic                wr_allowed;

  // ****************************************************************
  // Bus front end and step timer
  // ****************************************************************
  rps_axil_slave u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .req     (axil_req),
    .rsp     (axil_rsp),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  rps_step_timer u_tmr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (tmr_start),
    .busy    (tmr_busy)
  );

  // ****************************************************************
  // Per-regulator order compare
  // ****************************************************************
  // Regulators due at the current level share one step
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_hit
      assign level_hit[gi] = (st_q.snap[gi] == st_q.level);
    end
  endgenerate

  // Bypass check looks at the live fields, not a stale snapshot
  assign all_zero = (st_q.order == '0);

  // Pin request or software request, both on aclk already
  assign trigger = shutdown_req || st_q.sw_trig;

  // Order fields are frozen outside system-on and during a shutdown
  assign wr_allowed = system_on && (st_q.seq == SEQ_IDLE)
                      && !st_q.load_pend;

  // ****************************************************************
  // Read decode
  // ****************************************************************
  always_comb begin
    rd_data = '0;
    rd_ok   = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (rd_addr == {ORDER_IDX[i], 2'b00}) begin
        rd_data[ORDER_W-1:0] = st_q.order[i];
        rd_ok = 1'b1;
      end
    end
    if (rd_addr == {IDX_CTRL, 2'b00}) begin
      rd_data[CTRL_SW_SHUTDOWN_BIT] = st_q.sw_trig;
      rd_ok = 1'b1;
    end else if (rd_addr == {IDX_STATUS, 2'b00}) begin
      rd_data[NUM_REGS-1:0]    = st_q.enable;
      rd_data[STAT_BUSY_BIT]   = seq_busy;
      rd_data[STAT_DONE_BIT]   = seq_done;
      rd_data[STAT_LOADED_BIT] = st_q.loaded;
      rd_ok = 1'b1;
    end else if (rd_addr == {IDX_START, 2'b00}) begin
      rd_data[NUM_REGS*ORDER_W-1:0] = st_q.startup;
      rd_ok = 1'b1;
    end
  end

  // Address check for writes; read-only registers answer an error
  always_comb begin
    wr_ok = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (wr_addr == {ORDER_IDX[i], 2'b00}) begin
        wr_ok = 1'b1;
      end
    end
    if (wr_addr == {IDX_CTRL, 2'b00}) begin
      wr_ok = 1'b1;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d      = st_q;
    tmr_start = 1'b0;

    // Startup-order load (fused or test source) one edge after reset release
    if (st_q.load_pend) begin
      st_d.load_pend = 1'b0;
      st_d.loaded    = 1'b1;
      st_d.startup   = test_mode_config_source ? test_startup_order
                                               : fused_startup_order;
      st_d.order     = st_d.startup;
    end else if (wr_en && wr_allowed && wr_strb[0]) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (wr_addr == {ORDER_IDX[i], 2'b00}) begin
          st_d.order[i] = wr_data[ORDER_W-1:0];
        end
      end
    end

    case (st_q.seq)
      SEQ_IDLE: begin
        if (power_up_done) begin
          st_d.enable = ENABLE_RST;
        end
        if (trigger && !st_q.load_pend) begin
          st_d.sw_trig = 1'b0;
          st_d.snap    = st_q.order;
          if (all_zero) begin
            st_d.enable = '0;
            st_d.seq    = SEQ_DONE;
          end else begin
            st_d.level = '1;
            st_d.seq   = SEQ_SCAN;
          end
        end
      end
      SEQ_SCAN: begin
        if (level_hit != '0) begin
          st_d.enable = st_q.enable & ~level_hit;
          tmr_start   = 1'b1;
          st_d.seq    = SEQ_WAIT;
        end else if (st_q.level == '0) begin
          st_d.seq = SEQ_DONE;
        end else begin
          st_d.level = st_q.level - ORDER_W'(1);
        end
      end
      SEQ_WAIT: begin
        // Empty levels are skipped without waiting
        if (!tmr_busy) begin
          if (st_q.level == '0) begin
            st_d.seq = SEQ_DONE;
          end else begin
            st_d.level = st_q.level - ORDER_W'(1);
            st_d.seq   = SEQ_SCAN;
          end
        end
      end
      SEQ_DONE: begin
        // Rearm only when the request has dropped
        if (!shutdown_req) begin
          st_d.seq = SEQ_IDLE;
        end
      end
      default: begin
        st_d.seq = SEQ_IDLE;
      end
    endcase

    // Software request; a fresh write outweighs the clear at sequence start
    if (wr_en && wr_strb[0] && wr_addr == {IDX_CTRL, 2'b00}
        && wr_data[CTRL_SW_SHUTDOWN_BIT] && st_q.seq == SEQ_IDLE) begin
      st_d.sw_trig = 1'b1;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q.seq       <= SEQ_IDLE;
      st_q.load_pend <= 1'b1;
      st_q.loaded    <= 1'b0;
      st_q.order     <= {NUM_REGS{ORDER_RST}};
      st_q.startup   <= {NUM_REGS{ORDER_RST}};
      st_q.snap      <= {NUM_REGS{ORDER_RST}};
      st_q.level     <= '0;
      st_q.enable    <= ENABLE_RST;
      st_q.sw_trig   <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_enable    = st_q.enable;
  assign startup_order = st_q.startup;
  assign seq_busy      = (st_q.seq == SEQ_SCAN) || (st_q.seq == SEQ_WAIT);
  assign seq_done      = (st_q.seq == SEQ_DONE);

endmodule : rps_sequencer

/* rtl/rps_step_timer.sv */
// Purpose: Interval timer between shutdown steps
// Assumes: start is a one-cycle pulse from the sequencer
// Notes:   busy is high from the edge after start for STEP_CYCLES cycles

`timescale 1ns/1ps

module rps_step_timer
  import rps_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic start,
  output logic      busy
);

  typedef struct packed {
    logic [STEP_CNT_W-1:0] cnt;
  } rps_tmr_s;

  rps_tmr_s st_q;
  rps_tmr_s st_d;

  // Reload on start, otherwise count down to zero
  always_comb begin
    st_d = st_q;
    if (start) begin
      st_d.cnt = STEP_CNT_W'(STEP_CYCLES);
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - STEP_CNT_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy = (st_q.cnt != '0);

endmodule : rps_step_timer
